// >>> core/fine_cfg_regs.sv
`timescale 1ns/1ps

// Notes on behaviour
// (RULE1) Fine register bits [1:0] read the two low bits of the 12 V reading.
// (RULE2) Fine register bits [3:2] read the two low bits of remote one.
// (RULE3) Fine register bits [5:4] read the two low bits of local temperature.
// (RULE4) Fine register bits [7:6] read the two low bits of remote two.
// (RULE5) Reading fine register freezes it and high bytes until each high byte is read.
// (RULE6) Alert-select 1 makes pin ten the alert output, 0 the fan two drive.
// (RULE7) Override-select 1 enables override input on pin 22 and selected pin 14.
// (RULE8) Override-select 0 makes pin 22 the 2.5 V input, override disabled.
// (RULE9) Override pin drives out only when direction bits set, else timer input.
// (RULE10) Pin 14 follows its select field: speed, speed-or-override, alert, unused.
// (RULE11) Override asserted as input with failsafe_bit_a set forces all fans to full duty.
// (RULE12) Continuous-sense bit 5 measures fan two continuously without pulse stretch.
// (RULE13) Continuous-sense bit 6 measures fan three continuously without pulse stretch.
// (RULE14) Software sets continuous-sense bits only for dc-driven fans.
// (RULE15) Bits 4 and 7 do the same for fan one and fan four.
// (RULE16) With global lock set, configuration bits [3:0] ignore writes.
module fine_cfg_regs #(
    parameter int CHANNELS = fine_cfg_pkg::CHANNEL_COUNT,
    parameter int RWIDTH   = fine_cfg_pkg::READING_WIDTH
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // Register port
    input  wire logic [7:0]            regAddr,
    input  wire logic [7:0]            regWriteData,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic      [7:0]            regReadData_q,
    // Readings from the measurement engine
    input  wire logic [CHANNELS-1:0]   sampleValid,
    input  wire logic [RWIDTH*CHANNELS-1:0] sampleData,
    // Settings held by other registers
    input  wire logic                  globalLock,
    input  wire logic [2:0]            overrideDirBits,
    input  wire logic [1:0]            pin14Func,
    // Internal requests that the shared pins carry
    input  wire logic                  alertRequest,
    input  wire logic                  fanTwoDrive,
    input  wire logic                  overtempDrive,
    // Pin ten, alert or fan two drive output
    output logic                       pin10Out_q,
    output logic                       pin10OeN_q,
    // Pin 22, thermal override or 2.5 V input
    input  wire logic                  thermalOverridePinIn,
    output logic                       thermalOverridePinOut_q,
    output logic                       thermalOverridePinOeN_q,
    output logic                       voltageInputSelect_q,
    // Pin 14, fourth fan speed, override or alert
    input  wire logic                  pin14In,
    output logic                       pin14Out_q,
    output logic                       pin14OeN_q,
    output logic                       fanFourSpeedInput_q,
    // Results for the fan and timer logic
    output logic                       overrideAsserted_q,
    output logic                       fanFullDuty_q,
    output logic                       senseRateFast_q,
    output logic      [3:0]            continuousSense_q,
    output logic      [3:0]            pulseStretchEnable_q
);

    initial begin
        if (CHANNELS != fine_cfg_pkg::CHANNEL_COUNT) begin
            $error("fine register carries exactly four channels");
        end
        if (RWIDTH != fine_cfg_pkg::READING_WIDTH) begin
            $error("reading width must be ten bits");
        end
    end

    // Offset of the high-byte register of one channel
    function automatic logic [7:0] highOffset(input int ch);
        logic [7:0] off;
        off = fine_cfg_pkg::HIGH_OFFSET_0;
        if (ch == 1) begin
            off = fine_cfg_pkg::HIGH_OFFSET_1;
        end else if (ch == 2) begin
            off = fine_cfg_pkg::HIGH_OFFSET_2;
        end else if (ch == 3) begin
            off = fine_cfg_pkg::HIGH_OFFSET_3;
        end
        return off;
    endfunction : highOffset

    logic [7:0]          fine_q;
    logic [7:0]          config_q;
    logic [CHANNELS-1:0] freeze_q;
    logic [CHANNELS-1:0] highRead;
    logic [RWIDTH-1:0]   reading [CHANNELS];
    logic                readFine;
    logic                anyFrozen;
    logic                writeConfig;

    assign readFine    = regRead && (regAddr == fine_cfg_pkg::FINE_OFFSET);
    assign writeConfig = regWrite && (regAddr == fine_cfg_pkg::CONFIG_OFFSET);
    assign anyFrozen   = |freeze_q;

    // Per-channel snapshot, freeze flag and fine lane
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        localparam int LO = ch * fine_cfg_pkg::FINE_LANE_WIDTH;

        assign highRead[ch] = regRead && (regAddr == highOffset(ch));

        // Held from the fine read itself, so high byte matches what was returned
        reading_snapshot #(
            .WIDTH       (RWIDTH)
        ) reading_snapshot_i (
            .mclk        (mclk),
            .reset       (reset),
            .sampleValid (sampleValid[ch]),
            .sampleData  (sampleData[ch*RWIDTH +: RWIDTH]),
            .hold        (freeze_q[ch] || readFine),
            .value_q     (reading[ch])
        );

        // Freeze flag: set by a fine read, cleared by this channel's high read
        always_ff @(posedge mclk) begin
            if (reset) begin
                freeze_q[ch] <= 1'b0;
            end else if (readFine) begin
                freeze_q[ch] <= 1'b1; // RULE5
            end else if (highRead[ch]) begin
                freeze_q[ch] <= 1'b0; // RULE5
            end
        end

        // Lane follows the same sample as the snapshot while nothing is frozen
        always_ff @(posedge mclk) begin
            if (reset) begin
                fine_q[LO +: 2] <= fine_cfg_pkg::FINE_RESET[LO +: 2];
            end else if (sampleValid[ch] && !anyFrozen && !readFine) begin
                fine_q[LO +: 2] <= sampleData[ch*RWIDTH +: 2]; // RULE1 RULE2 RULE3 RULE4
            end
        end
    end

    // Configuration; lockable low nibble keeps its value once locked
    always_ff @(posedge mclk) begin
        if (reset) begin
            config_q <= fine_cfg_pkg::CONFIG_RESET;
        end else if (writeConfig) begin
            config_q[7:4] <= regWriteData[7:4];
            if (!globalLock) begin
                config_q[3:0] <= regWriteData[3:0]; // RULE16
            end
        end
    end

    // Read data for the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            regReadData_q <= fine_cfg_pkg::UNMAPPED_READ;
        end else if (regRead) begin
            if (regAddr == fine_cfg_pkg::FINE_OFFSET) begin
                regReadData_q <= fine_q; // RULE1 RULE2 RULE3 RULE4
            end else if (regAddr == fine_cfg_pkg::CONFIG_OFFSET) begin
                regReadData_q <= config_q;
            end else if (highRead[0]) begin
                regReadData_q <= reading[0][RWIDTH-1:2];
            end else if (highRead[1]) begin
                regReadData_q <= reading[1][RWIDTH-1:2];
            end else if (highRead[2]) begin
                regReadData_q <= reading[2][RWIDTH-1:2];
            end else if (highRead[3]) begin
                regReadData_q <= reading[3][RWIDTH-1:2];
            end else begin
                regReadData_q <= fine_cfg_pkg::UNMAPPED_READ;
            end
        end
    end

    // Pin inputs cross in through two flops; first stage feeds only the second
    logic [1:0] overrideSync_q;
    logic [1:0] pin14Sync_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            overrideSync_q <= 2'h3;
            pin14Sync_q    <= 2'h3;
        end else begin
            overrideSync_q <= {overrideSync_q[0], thermalOverridePinIn};
            pin14Sync_q    <= {pin14Sync_q[0], pin14In};
        end
    end

    logic alertSelect;
    logic overrideSelect;
    logic boostSelect;
    logic overrideBidir;
    logic pin14IsOverride;
    logic pin14IsAlert;
    logic overrideLevel;

    assign alertSelect     = config_q[fine_cfg_pkg::ALERT_SELECT_BIT];
    assign overrideSelect  = config_q[fine_cfg_pkg::OVERRIDE_SELECT_BIT];
    assign boostSelect     = config_q[fine_cfg_pkg::FAILSAFE_BIT_A_BIT];
    // Any set direction bit makes the override pin bidirectional
    assign overrideBidir   = |overrideDirBits; // RULE9
    assign pin14IsOverride = overrideSelect &&
                             (pin14Func == fine_cfg_pkg::PIN14_OVERRIDE); // RULE10 RULE7
    assign pin14IsAlert    = (pin14Func == fine_cfg_pkg::PIN14_ALERT); // RULE10

    // Own pull-down reaches the logic two cycles late, so keep it masked that long
    logic [1:0] selfDriveDly_q;
    logic       selfDriven;

    always_ff @(posedge mclk) begin
        if (reset) begin
            selfDriveDly_q <= '0;
        end else begin
            selfDriveDly_q <= {selfDriveDly_q[0], !thermalOverridePinOeN_q};
        end
    end

    assign selfDriven = !thermalOverridePinOeN_q || (|selfDriveDly_q);

    // Override pin is active low; our own drive must not read back as asserted
    assign overrideLevel = (overrideSelect && !overrideSync_q[1] && !selfDriven) ||
                           (pin14IsOverride && !pin14Sync_q[1]); // RULE7 RULE8

    // Pin ten: open-drain alert, or push-pull fan two drive
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin10Out_q <= 1'b0;
            pin10OeN_q <= 1'b0;
        end else if (alertSelect) begin
            pin10Out_q <= 1'b0; // RULE6
            pin10OeN_q <= !alertRequest; // RULE6
        end else begin
            pin10Out_q <= fanTwoDrive; // RULE6
            pin10OeN_q <= 1'b0;
        end
    end

    // Pin 22: override with optional open-drain drive, or voltage input
    always_ff @(posedge mclk) begin
        if (reset) begin
            thermalOverridePinOut_q <= 1'b0;
            thermalOverridePinOeN_q <= 1'b1;
            voltageInputSelect_q    <= 1'b1;
        end else begin
            thermalOverridePinOut_q <= 1'b0;
            thermalOverridePinOeN_q <= !(overrideSelect && overrideBidir
                                         && overtempDrive); // RULE9 RULE8
            voltageInputSelect_q    <= !overrideSelect; // RULE8
        end
    end

    // Pin 14: speed input, override input, or open-drain alert
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin14Out_q          <= 1'b0;
            pin14OeN_q          <= 1'b1;
            fanFourSpeedInput_q <= 1'b1;
        end else begin
            pin14Out_q          <= 1'b0;
            pin14OeN_q          <= !(pin14IsAlert && alertRequest); // RULE10
            // Unused code and non-speed modes park the speed input high
            fanFourSpeedInput_q <= (pin14IsOverride || pin14IsAlert ||
                                    pin14Func == fine_cfg_pkg::PIN14_NONE)
                                   ? 1'b1 : pin14Sync_q[1]; // RULE10
        end
    end

    // Override state and fail-safe failsafe_bit_a; failsafe_bit_a only when pin acts as input
    always_ff @(posedge mclk) begin
        if (reset) begin
            overrideAsserted_q <= 1'b0;
            fanFullDuty_q      <= 1'b0;
        end else begin
            overrideAsserted_q <= overrideLevel; // RULE7
            fanFullDuty_q      <= overrideLevel && boostSelect; // RULE11
        end
    end

    // Continuous-sense field, one bit per fan
    logic [3:0] contBits;
    assign contBits = config_q[fine_cfg_pkg::CONT_SENSE_LSB +: 4];

    // Speed sensing; continuous sensing drops pulse stretching per fan
    always_ff @(posedge mclk) begin
        if (reset) begin
            senseRateFast_q      <= 1'b0;
            continuousSense_q    <= 4'h0;
            pulseStretchEnable_q <= 4'hf;
        end else begin
            senseRateFast_q      <= config_q[fine_cfg_pkg::SENSE_RATE_BIT];
            // Software must only set these for dc-driven fans
            continuousSense_q    <= contBits; // RULE12 RULE13 RULE15
            pulseStretchEnable_q <= ~contBits; // RULE12 RULE13 RULE15
        end
    end

    // Fine read answers fine_q one cycle later
    fine_read_a: assert property (@(posedge mclk) disable iff (reset) // RULE1
        readFine |=> regReadData_q == $past(fine_q))
        else $error("fine read returned wrong data");

    // Remote one lane bits track new samples while free
    fine_lane_a: assert property (@(posedge mclk) disable iff (reset) // RULE2
        sampleValid[1] && !anyFrozen && !readFine |=> fine_q[3:2] == $past(sampleData[11:10]))
        else $error("remote one lane did not follow sample");

    // Frozen fine register stays put
    fine_frozen_a: assert property (@(posedge mclk) disable iff (reset) // RULE5
        anyFrozen || readFine |=> $stable(fine_q))
        else $error("fine register changed while frozen");

    // Freeze lasts until the high byte is read
    freeze_clear_a: assert property (@(posedge mclk) disable iff (reset) // RULE5
        freeze_q[0] && !highRead[0] && !readFine |=> freeze_q[0])
        else $error("freeze released without high read");

    // Pin ten follows the alert select
    pin10_mode_a: assert property (@(posedge mclk) disable iff (reset) // RULE6
        !alertSelect |=> pin10Out_q == $past(fanTwoDrive) && !pin10OeN_q)
        else $error("pin ten not carrying fan two drive");

    // Voltage input mode never drives pin 22
    pin22_quiet_a: assert property (@(posedge mclk) disable iff (reset) // RULE8
        !overrideSelect |=> voltageInputSelect_q && thermalOverridePinOeN_q)
        else $error("pin 22 driven in voltage mode");

    // No direction bits means pin 22 never drives
    pin22_input_a: assert property (@(posedge mclk) disable iff (reset) // RULE9
        overrideDirBits == 3'h0 |=> thermalOverridePinOeN_q)
        else $error("override pin driven while input only");

    // Failsafe_bit_a follows an asserted override input on the next cycle
    failsafe_bit_a_follow_a: assert property (@(posedge mclk) disable iff (reset) // RULE11
        boostSelect && overrideSelect && !selfDriven && !overrideSync_q[1] |=> fanFullDuty_q)
        else $error("failsafe_bit_a did not force full duty");

    // Locked nibble ignores writes
    lock_hold_a: assert property (@(posedge mclk) disable iff (reset) // RULE16
        writeConfig && globalLock |=> config_q[3:0] == $past(config_q[3:0]))
        else $error("locked bits were written");

    // Each fan's sense mode follows its configuration bit a cycle later
    cont_sense_a: assert property (@(posedge mclk) disable iff (reset) // RULE12
        1'b1 |=> continuousSense_q == $past(contBits)
                 && pulseStretchEnable_q == ~$past(contBits))
        else $error("sense mode does not follow configuration");

    // Pin 14 pulls low in alert mode when an alert is requested
    pin14_alert_a: assert property (@(posedge mclk) disable iff (reset) // RULE10
        pin14IsAlert && alertRequest |=> !pin14OeN_q && !pin14Out_q)
        else $error("pin 14 did not signal alert");

endmodule : fine_cfg_regs

// >>> core/fine_cfg_pkg.sv
package fine_cfg_pkg;

    // Register offsets on the byte-wide register port
    localparam logic [7:0] FINE_OFFSET    = 8'h77;
    localparam logic [7:0] CONFIG_OFFSET  = 8'h78;
    // High-byte reading registers, one per channel, in channel order
    localparam logic [7:0] HIGH_OFFSET_0  = 8'hf0;
    localparam logic [7:0] HIGH_OFFSET_1  = 8'hf1;
    localparam logic [7:0] HIGH_OFFSET_2  = 8'hf2;
    localparam logic [7:0] HIGH_OFFSET_3  = 8'hf3;

    // Reset values
    localparam logic [7:0] FINE_RESET     = 8'h00;
    localparam logic [7:0] CONFIG_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;
    localparam logic [9:0] READING_RESET  = 10'h000;

    // Configuration field positions
    localparam int ALERT_SELECT_BIT    = 0;
    localparam int OVERRIDE_SELECT_BIT = 1;
    localparam int FAILSAFE_BIT_A_BIT           = 2;
    localparam int SENSE_RATE_BIT      = 3;
    localparam int CONT_SENSE_LSB      = 4;
    localparam int LOCKABLE_MSB        = 3;

    // Fine-reading lanes: channel i lives in bits [2i+1:2i]
    localparam int FINE_LANE_WIDTH     = 2;
    localparam int CHANNEL_COUNT       = 4;
    localparam int READING_WIDTH       = 10;

    // Fourth fan-sense pin function codes
    typedef enum logic [1:0] {
        PIN14_SPEED    = 2'h0,
        PIN14_OVERRIDE = 2'h1,
        PIN14_ALERT    = 2'h2,
        PIN14_NONE     = 2'h3
    } pin14_func_type;

endpackage : fine_cfg_pkg

// >>> core/reading_snapshot.sv
`timescale 1ns/1ps

// One measurement channel: captures each new reading unless held
module reading_snapshot #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // New reading from the measurement engine
    input  wire logic             sampleValid,
    input  wire logic [WIDTH-1:0] sampleData,
    // Hold request from the freeze logic
    input  wire logic             hold,
    // Captured reading
    output logic      [WIDTH-1:0] value_q
);

    initial begin
        if (WIDTH < 3) begin
            $error("reading_snapshot needs at least three bits");
        end
    end

    // Capture; a held channel ignores fresh samples entirely
    always_ff @(posedge mclk) begin
        if (reset) begin
            value_q <= '0;
        end else if (sampleValid && !hold) begin
            value_q <= sampleData;
        end
    end

    // A held value never changes
    hold_stable_a: assert property (@(posedge mclk) disable iff (reset) // RULE5
        hold |=> $stable(value_q))
        else $error("held reading changed");

endmodule : reading_snapshot

// >>> testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    // Clock and reset
    logic        mclk;
    logic        reset;
    // Register port
    logic [7:0]  regAddr;
    logic [7:0]  regWriteData;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regReadData_q;
    // Readings and settings
    logic [3:0]  sampleValid;
    logic [39:0] sampleData;
    logic        globalLock;
    logic [2:0]  overrideDirBits;
    logic [1:0]  pin14Func;
    logic        alertRequest;
    logic        fanTwoDrive;
    logic        overtempDrive;
    // Far-side pin levels and resolved wires
    logic        ext22;
    logic        ext14;
    logic        pin22Wire;
    logic        pin14Wire;
    // Design outputs
    logic        pin10Out_q;
    logic        pin10OeN_q;
    logic        thermalOverridePinOut_q;
    logic        thermalOverridePinOeN_q;
    logic        voltageInputSelect_q;
    logic        pin14Out_q;
    logic        pin14OeN_q;
    logic        fanFourSpeedInput_q;
    logic        overrideAsserted_q;
    logic        fanFullDuty_q;
    logic        senseRateFast_q;
    logic [3:0]  continuousSense_q;
    logic [3:0]  pulseStretchEnable_q;
    int          numErrors;
    int          totalChecks;

    // Readings with four distinct low-bit lanes
    localparam logic [39:0] SET_A = {10'h2c4, 10'h1bb, 10'h37e, 10'h0a1};

    // Open-drain wires: low when the far side or the design pulls
    assign pin22Wire = ext22 & (thermalOverridePinOeN_q | thermalOverridePinOut_q);
    assign pin14Wire = ext14 & (pin14OeN_q | pin14Out_q);

    fine_cfg_regs fine_cfg_regs_i (
        .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData_q(regReadData_q),
        .sampleValid(sampleValid), .sampleData(sampleData), .globalLock(globalLock),
        .overrideDirBits(overrideDirBits), .pin14Func(pin14Func),
        .alertRequest(alertRequest), .fanTwoDrive(fanTwoDrive),
        .overtempDrive(overtempDrive), .pin10Out_q(pin10Out_q), .pin10OeN_q(pin10OeN_q),
        .thermalOverridePinIn(pin22Wire), .thermalOverridePinOut_q(thermalOverridePinOut_q),
        .thermalOverridePinOeN_q(thermalOverridePinOeN_q),
        .voltageInputSelect_q(voltageInputSelect_q), .pin14In(pin14Wire),
        .pin14Out_q(pin14Out_q), .pin14OeN_q(pin14OeN_q),
        .fanFourSpeedInput_q(fanFourSpeedInput_q), .overrideAsserted_q(overrideAsserted_q),
        .fanFullDuty_q(fanFullDuty_q), .senseRateFast_q(senseRateFast_q),
        .continuousSense_q(continuousSense_q), .pulseStretchEnable_q(pulseStretchEnable_q)
    );

    // Clock at 5 ns period
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Expected fine byte: low two bits of each channel in lane order
    function automatic logic [7:0] fineOf(input logic [39:0] s);
        return {s[31:30], s[21:20], s[11:10], s[1:0]};
    endfunction : fineOf

    task automatic tallyAndFinish();
        if (numErrors == 0 && totalChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tallyAndFinish

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr

    // Data stands from the cycle after the strobe is taken until the next read strobe
    task automatic rdCheck(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        check(regReadData_q, exp);
    endtask : rdCheck

    task automatic load(input logic [39:0] s);
        @(posedge mclk);
        sampleValid <= 4'hf;
        sampleData <= s;
        @(posedge mclk);
        sampleValid <= 4'h0;
    endtask : load

    task automatic testReset();
        int i;
        rdCheck(fine_cfg_pkg::FINE_OFFSET, fine_cfg_pkg::FINE_RESET);
        // The fine read froze every channel; high reads thaw them again
        for (i = 0; i < 4; i++) begin
            rdCheck(fine_cfg_pkg::HIGH_OFFSET_0 + 8'(i), fine_cfg_pkg::READING_RESET[9:2]);
        end
        rdCheck(fine_cfg_pkg::CONFIG_OFFSET, fine_cfg_pkg::CONFIG_RESET);
        rdCheck(8'h10, fine_cfg_pkg::UNMAPPED_READ);
        check({4'h0, pulseStretchEnable_q}, 8'h0f);
        check({7'h0, voltageInputSelect_q}, 8'h01);
    endtask : testReset

    // Freeze holds old readings while new samples arrive
    task automatic testFreeze();
        int i;
        load(SET_A);
        rdCheck(fine_cfg_pkg::FINE_OFFSET, fineOf(SET_A));
        load(~SET_A);
        wr(fine_cfg_pkg::FINE_OFFSET, 8'hff);
        rdCheck(fine_cfg_pkg::FINE_OFFSET, fineOf(SET_A));
        for (i = 0; i < 4; i++) begin
            rdCheck(fine_cfg_pkg::HIGH_OFFSET_0 + 8'(i), SET_A[10*i+2 +: 8]);
        end
        load(~SET_A);
        rdCheck(fine_cfg_pkg::FINE_OFFSET, fineOf(~SET_A));
        for (i = 0; i < 4; i++) begin
            rdCheck(fine_cfg_pkg::HIGH_OFFSET_0 + 8'(i), ~SET_A[10*i+2 +: 8]);
        end
    endtask : testFreeze

    // One fan at a time, each taken as dc-driven
    task automatic testSense();
        int i;
        for (i = 0; i < 4; i++) begin
            wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h10 << i);
            settle(2);
            check({4'h0, continuousSense_q}, 8'h01 << i);
            check({4'h0, pulseStretchEnable_q}, 8'h0f ^ (8'h01 << i));
        end
    endtask : testSense

    // Locked low nibble ignores writes; unmapped write changes nothing
    task automatic testLock();
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h00);
        @(posedge mclk);
        globalLock <= 1'b1;
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'hff);
        rdCheck(fine_cfg_pkg::CONFIG_OFFSET, 8'hf0);
        @(posedge mclk);
        globalLock <= 1'b0;
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h0f);
        wr(8'h10, 8'haa);
        rdCheck(fine_cfg_pkg::CONFIG_OFFSET, 8'h0f);
        check({7'h0, senseRateFast_q}, 8'h01);
    endtask : testLock

    task automatic testPin10();
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h01);
        alertRequest <= 1'b1;
        settle(2);
        check({6'h0, pin10Out_q, pin10OeN_q}, 8'h00);
        @(posedge mclk);
        alertRequest <= 1'b0;
        settle(2);
        check({7'h0, pin10OeN_q}, 8'h01);
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h00);
        fanTwoDrive <= 1'b1;
        settle(2);
        check({6'h0, pin10Out_q, pin10OeN_q}, 8'h02);
    endtask : testPin10

    task automatic testOverride();
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h04);
        ext22 <= 1'b0;
        settle(4);
        check({6'h0, voltageInputSelect_q, overrideAsserted_q}, 8'h02);
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h06);
        settle(4);
        check({7'h0, voltageInputSelect_q}, 8'h00);
        check({6'h0, overrideAsserted_q, fanFullDuty_q}, 8'h03);
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h02);
        settle(2);
        check({7'h0, fanFullDuty_q}, 8'h00);
        @(posedge mclk);
        ext22 <= 1'b1;
        settle(4);
        check({7'h0, overrideAsserted_q}, 8'h00);
        // Own pull-down on the pin must not read back as an assertion
        @(posedge mclk);
        overtempDrive <= 1'b1;
        settle(4);
        check({7'h0, thermalOverridePinOeN_q}, 8'h01);
        @(posedge mclk);
        overrideDirBits <= 3'h4;
        settle(4);
        check({6'h0, thermalOverridePinOeN_q, overrideAsserted_q}, 8'h00);
        check({6'h0, thermalOverridePinOut_q, pin14Out_q}, 8'h00);
        @(posedge mclk);
        overrideDirBits <= 3'h0;
        overtempDrive <= 1'b0;
        settle(4);
        check({6'h0, thermalOverridePinOeN_q, overrideAsserted_q}, 8'h02);
    endtask : testOverride

    // Every pin 14 function code with override-select set
    task automatic testPin14();
        int c;
        alertRequest <= 1'b1;
        ext14 <= 1'b0;
        for (c = 0; c < 4; c++) begin
            @(posedge mclk);
            pin14Func <= 2'(c);
            settle(4);
            check({7'h0, fanFourSpeedInput_q}, {7'h0, c != 0});
            check({7'h0, overrideAsserted_q}, {7'h0, c == 1});
            check({7'h0, pin14OeN_q}, {7'h0, c != 2});
        end
        @(posedge mclk);
        pin14Func <= 2'h1;
        wr(fine_cfg_pkg::CONFIG_OFFSET, 8'h00);
        settle(4);
        check({6'h0, fanFourSpeedInput_q, overrideAsserted_q}, 8'h00);
    endtask : testPin14

    // Stimulus: inputs settle at time zero, reset spans two edges
    initial begin
        numErrors = 0;
        totalChecks = 0;
        reset = 1'b1;
        {regAddr, regWriteData, regWrite, regRead} = '0;
        {sampleValid, sampleData, globalLock, overrideDirBits, pin14Func} = '0;
        {alertRequest, fanTwoDrive, overtempDrive} = '0;
        ext22 = 1'b1;
        ext14 = 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        testReset();
        testFreeze();
        testSense();
        testLock();
        testPin10();
        testOverride();
        testPin14();
        tallyAndFinish();
    end

    // Watchdog well past the roughly 150 cycles the run needs
    initial begin
        #50000;
        numErrors++;
        tallyAndFinish();
    end

endmodule : tb_top
